//--- verilog/dsv_top.sv
// display scaler control and virtual-screen start address logic
// Operation
// RQ1: no scaling while TV on with interlace
// RQ2: software uses simple-scaling register for interlace
// RQ3: input width is count minus one, nonzero
// RQ4: input height is count minus one, nonzero
// RQ5: output width is direct count, nonzero
// RQ6: output height is direct count, nonzero
// RQ7: first stage bypass or divide by 2^n
// RQ8: interpolation modes, two only for down-scaling
// RQ9: bypass bit stops second stage scaling
// RQ10: horizontal coefficient clamped by ceiling/floor
// RQ11: vertical coefficient clamped by ceiling/floor
// RQ12: initial horizontal and vertical numerators
// RQ13: software computes numerators from ratios
// RQ14: exact 2x2 up-scaling ignores numerators
// RQ15: image 0 start is base plus skew
// RQ16: line length gives frame-buffer stride
// RQ17: image 1 has the same scroll fields
// RQ18: software rewrites base and offset to scroll
// RQ19: pixel-format code maps to bits per pixel
// RQ20: reserved bits read zero, writes ignored
//
// Chosen here: the address-and-strobe port.
`default_nettype none
`timescale 1ns/10ps
module dsv_top
  import dsv_pkg::*;
(
  input  wire logic                  CORE_CLK_I,
  input  wire logic                  RST_N_I,
  input  wire logic                  CE_I,
  input  wire logic [12:0]           REG_ADDR_I,
  input  wire logic [31:0]           REG_WDATA_I,
  input  wire logic                  REG_WR_I,
  input  wire logic                  REG_RD_I,
  output logic      [31:0]           REG_RDATA_O,
  input  wire logic                  TV_EN_I,
  input  wire logic                  IN_INTERLACE_I,
  input  wire logic                  OUT_INTERLACE_I,
  input  wire logic [TH_W-1:0]       H_COEF_I,
  input  wire logic [TH_W-1:0]       V_COEF_I,
  input  wire logic [31:0]           IMG0_BASE_ADDR_I,
  input  wire logic [31:0]           IMG1_BASE_ADDR_I,
  input  wire logic [2:0]            IMG0_PIXEL_FORMAT_I,
  input  wire logic [2:0]            IMG1_PIXEL_FORMAT_I,
  output logic                       SCALE_ACTIVE_O,
  output logic [2:0]                 FIRST_SHIFT_O,
  output logic [12:0]                MID_W_O,
  output logic [12:0]                MID_H_O,
  output logic [1:0]                 H_MODE_O,
  output logic [1:0]                 V_MODE_O,
  output logic [TH_W-1:0]            H_COEF_O,
  output logic [TH_W-1:0]            V_COEF_O,
  output logic [NUM_W-1:0]           H_INIT_NUM_O,
  output logic [NUM_W-1:0]           V_INIT_NUM_O,
  output logic                       NUM_IGNORED_O,
  output logic [31:0]                IMG0_START_O,
  output logic [31:0]                IMG1_START_O,
  output logic [STRIDE_B_W-1:0]      IMG0_STRIDE_O,
  output logic [STRIDE_B_W-1:0]      IMG1_STRIDE_O
);

  // ***************************************************
  // register storage
  // ***************************************************
  logic [IN_DIM_W-1:0]  in_w_q;
  logic [IN_DIM_W-1:0]  in_h_q;
  logic [OUT_DIM_W-1:0] out_w_q;
  logic [OUT_DIM_W-1:0] out_h_q;
  logic [2:0]           fir_sel_q;
  logic [1:0]           hmode_q;
  logic [1:0]           vmode_q;
  logic                 bypass_q;
  logic [TH_W-1:0]      h_ceil_q;
  logic [TH_W-1:0]      h_flr_q;
  logic [TH_W-1:0]      v_ceil_q;
  logic [TH_W-1:0]      v_flr_q;
  logic [NUM_W-1:0]     h_num_q;
  logic [NUM_W-1:0]     v_num_q;
  logic                 img0_scroll_on_q;
  logic [SKEW_W-1:0]    img0_start_skew_q;
  logic [STRIDE_W-1:0]  img0_line_stride_q;
  logic                 img1_scroll_on_q;
  logic [SKEW_W-1:0]    img1_start_skew_q;
  logic [STRIDE_W-1:0]  img1_line_stride_q;
  dsv_state_e           st_q;
  dsv_state_e           st_d;
  logic [31:0]          rdata_q;

  // ***************************************************
  // write decode
  // ***************************************************
  wire logic wr_in_w   = REG_WR_I && (REG_ADDR_I == OFS_IN_W);
  wire logic wr_in_h   = REG_WR_I && (REG_ADDR_I == OFS_IN_H);
  wire logic wr_out_w  = REG_WR_I && (REG_ADDR_I == OFS_OUT_W);
  wire logic wr_out_h  = REG_WR_I && (REG_ADDR_I == OFS_OUT_H);
  wire logic wr_misc   = REG_WR_I && (REG_ADDR_I == OFS_MISC);
  wire logic wr_h_ceil = REG_WR_I && (REG_ADDR_I == OFS_H_CEIL);
  wire logic wr_h_flr  = REG_WR_I && (REG_ADDR_I == OFS_H_FLR);
  wire logic wr_v_ceil = REG_WR_I && (REG_ADDR_I == OFS_V_CEIL);
  wire logic wr_v_flr  = REG_WR_I && (REG_ADDR_I == OFS_V_FLR);
  wire logic wr_num    = REG_WR_I && (REG_ADDR_I == OFS_NUM);
  wire logic wr_scr0   = REG_WR_I && (REG_ADDR_I == OFS_SCR0);
  wire logic wr_scr1   = REG_WR_I && (REG_ADDR_I == OFS_SCR1);

  // ***************************************************
  // scaler geometry and legality
  // ***************************************************
  wire logic [12:0] mid_w = first_stage(in_w_q, fir_sel_q); // [RQ7]
  wire logic [12:0] mid_h = first_stage(in_h_q, fir_sel_q); // [RQ7]
  wire logic h_up = {1'b0, out_w_q} > {1'b0, mid_w};
  wire logic v_up = {1'b0, out_h_q} > {1'b0, mid_h};
  wire logic is_2x2 = ({1'b0, out_w_q} == {1'b0, mid_w, 1'b0}) &&
                      ({1'b0, out_h_q} == {1'b0, mid_h, 1'b0});
  wire logic in_ok = (in_w_q != 12'h000) && (in_w_q <= IN_MAX) && // [RQ3]
                     (in_h_q != 12'h000) && (in_h_q <= IN_MAX);   // [RQ4]
  wire logic out_w_ok = (out_w_q != 14'h0000) && (out_w_q <= OUT_MAX); // [RQ5]
  wire logic out_h_ok = (out_h_q != 14'h0000) && (out_h_q <= OUT_MAX); // [RQ6]
  // threshold and nearest modes only make sense when shrinking
  wire logic h_mode_ok = (hmode_q != INTERP_RSVD) && !(h_up && (hmode_q != INTERP_BILIN)); // [RQ8]
  wire logic v_mode_ok = (vmode_q != INTERP_RSVD) && !(v_up && (vmode_q != INTERP_BILIN)); // [RQ8]
  wire logic cfg_ok = in_ok && out_w_ok && out_h_ok && h_mode_ok && v_mode_ok;
  wire logic tv_block = TV_EN_I && (IN_INTERLACE_I || OUT_INTERLACE_I); // [RQ1]

  wire logic [TH_W-1:0] h_coef_d = h_up ? clamp9(H_COEF_I, h_flr_q, h_ceil_q) : H_COEF_I; // [RQ10]
  wire logic [TH_W-1:0] v_coef_d = v_up ? clamp9(V_COEF_I, v_flr_q, v_ceil_q) : V_COEF_I; // [RQ11]
  // the fixed 2x2 path uses its own phase, so the loaded numerators are masked
  wire logic [NUM_W-1:0] h_num_d = is_2x2 ? 8'h00 : h_num_q; // [RQ12] [RQ14]
  wire logic [NUM_W-1:0] v_num_d = is_2x2 ? 8'h00 : v_num_q; // [RQ12] [RQ14]

  always_comb
  begin
    st_d = ST_RUN;
    if (bypass_q || !cfg_ok)
      st_d = ST_OFF; // [RQ9]
    else if (tv_block)
      st_d = ST_HOLD; // [RQ1]
  end

  // ***************************************************
  // virtual screen address
  // ***************************************************
  wire logic [31:0]           start0;
  wire logic [31:0]           start1;
  wire logic [STRIDE_B_W-1:0] stride0;
  wire logic [STRIDE_B_W-1:0] stride1;

  dsv_scroll_addr u_img0 (
    .base_i     (IMG0_BASE_ADDR_I),
    .on_i       (img0_scroll_on_q),
    .skew_i     (img0_start_skew_q),
    .stride_i   (img0_line_stride_q),
    .fmt_i      (IMG0_PIXEL_FORMAT_I),
    .start_o    (start0),
    .stride_b_o (stride0)
  ); // [RQ15]

  dsv_scroll_addr u_img1 (
    .base_i     (IMG1_BASE_ADDR_I),
    .on_i       (img1_scroll_on_q),
    .skew_i     (img1_start_skew_q),
    .stride_i   (img1_line_stride_q),
    .fmt_i      (IMG1_PIXEL_FORMAT_I),
    .start_o    (start1),
    .stride_b_o (stride1)
  ); // [RQ17]

  // ***************************************************
  // read mux
  // ***************************************************
  wire logic [31:0] stat_word = {28'h0000000, NUM_IGNORED_O, !cfg_ok, st_q == ST_HOLD, st_q == ST_RUN};
  wire logic [31:0] misc_word = {23'h000000, fir_sel_q, 1'b0, hmode_q, vmode_q, bypass_q};
  wire logic [31:0] scr0_word = {11'h000, img0_scroll_on_q, 3'h0, img0_start_skew_q, img0_line_stride_q};
  wire logic [31:0] scr1_word = {11'h000, img1_scroll_on_q, 3'h0, img1_start_skew_q, img1_line_stride_q};
  logic [31:0] rd_word;

  // reserved bits are never stored, so they read back as zero
  always_comb
  begin
    case (REG_ADDR_I)
      OFS_IN_W:   rd_word = {20'h00000, in_w_q}; // [RQ20]
      OFS_IN_H:   rd_word = {20'h00000, in_h_q};
      OFS_OUT_W:  rd_word = {18'h00000, out_w_q};
      OFS_OUT_H:  rd_word = {18'h00000, out_h_q};
      OFS_MISC:   rd_word = misc_word;
      OFS_H_CEIL: rd_word = {23'h000000, h_ceil_q};
      OFS_H_FLR:  rd_word = {23'h000000, h_flr_q};
      OFS_V_CEIL: rd_word = {23'h000000, v_ceil_q};
      OFS_V_FLR:  rd_word = {23'h000000, v_flr_q};
      OFS_NUM:    rd_word = {16'h0000, h_num_q, v_num_q};
      OFS_STAT:   rd_word = stat_word;
      OFS_SCR0:   rd_word = scr0_word;
      OFS_SCR1:   rd_word = scr1_word;
      default:    rd_word = 32'h00000000;
    endcase
  end

  // ***************************************************
  // register writes
  // ***************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      in_w_q   <= 12'h000;
      in_h_q   <= 12'h000;
      out_w_q  <= 14'h0000;
      out_h_q  <= 14'h0000;
      fir_sel_q <= 3'h0;
      hmode_q  <= 2'h0;
      vmode_q  <= 2'h0;
      bypass_q <= BYPASS_RST;
      h_ceil_q <= 9'h000;
      h_flr_q  <= 9'h000;
      v_ceil_q <= 9'h000;
      v_flr_q  <= 9'h000;
      h_num_q  <= 8'h00;
      v_num_q  <= 8'h00;
    end
    else if (CE_I)
    begin
      if (wr_in_w) in_w_q <= REG_WDATA_I[IN_DIM_W-1:0]; // [RQ3] [RQ20]
      if (wr_in_h) in_h_q <= REG_WDATA_I[IN_DIM_W-1:0]; // [RQ4]
      if (wr_out_w) out_w_q <= REG_WDATA_I[OUT_DIM_W-1:0]; // [RQ5]
      if (wr_out_h) out_h_q <= REG_WDATA_I[OUT_DIM_W-1:0]; // [RQ6]
      if (wr_misc)
      begin
        fir_sel_q <= REG_WDATA_I[MISC_FIR_LSB+:3];
        hmode_q   <= REG_WDATA_I[MISC_HMOD_LSB+:2];
        vmode_q   <= REG_WDATA_I[MISC_VMOD_LSB+:2];
        bypass_q  <= REG_WDATA_I[MISC_BYP_BIT]; // [RQ9]
      end
      if (wr_h_ceil) h_ceil_q <= REG_WDATA_I[TH_W-1:0];
      if (wr_h_flr) h_flr_q <= REG_WDATA_I[TH_W-1:0];
      if (wr_v_ceil) v_ceil_q <= REG_WDATA_I[TH_W-1:0];
      if (wr_v_flr) v_flr_q <= REG_WDATA_I[TH_W-1:0];
      if (wr_num)
      begin
        h_num_q <= REG_WDATA_I[NUM_H_LSB+:NUM_W]; // [RQ12]
        v_num_q <= REG_WDATA_I[NUM_W-1:0]; // [RQ12]
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      img0_scroll_on_q   <= 1'b0;
      img0_start_skew_q  <= 5'h00;
      img0_line_stride_q <= 12'h000;
      img1_scroll_on_q   <= 1'b0;
      img1_start_skew_q  <= 5'h00;
      img1_line_stride_q <= 12'h000;
    end
    else if (CE_I)
    begin
      if (wr_scr0)
      begin
        img0_scroll_on_q   <= REG_WDATA_I[SCR_EN_BIT]; // [RQ15]
        img0_start_skew_q  <= REG_WDATA_I[SCR_SKEW_LSB+:SKEW_W];
        img0_line_stride_q <= REG_WDATA_I[STRIDE_W-1:0]; // [RQ16]
      end
      if (wr_scr1)
      begin
        img1_scroll_on_q   <= REG_WDATA_I[SCR_EN_BIT]; // [RQ17]
        img1_start_skew_q  <= REG_WDATA_I[SCR_SKEW_LSB+:SKEW_W];
        img1_line_stride_q <= REG_WDATA_I[STRIDE_W-1:0];
      end
    end
  end

  // ***************************************************
  // registered outputs
  // ***************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_q           <= ST_OFF;
      rdata_q        <= 32'h00000000;
      SCALE_ACTIVE_O <= 1'b0;
      FIRST_SHIFT_O  <= 3'h0;
      MID_W_O        <= 13'h0000;
      MID_H_O        <= 13'h0000;
      H_MODE_O       <= 2'h0;
      V_MODE_O       <= 2'h0;
      H_COEF_O       <= 9'h000;
      V_COEF_O       <= 9'h000;
      H_INIT_NUM_O   <= 8'h00;
      V_INIT_NUM_O   <= 8'h00;
      NUM_IGNORED_O  <= 1'b0;
      IMG0_START_O   <= 32'h00000000;
      IMG1_START_O   <= 32'h00000000;
      IMG0_STRIDE_O  <= 15'h0000;
      IMG1_STRIDE_O  <= 15'h0000;
    end
    else if (CE_I)
    begin
      st_q           <= st_d;
      rdata_q        <= REG_RD_I ? rd_word : 32'h00000000;
      SCALE_ACTIVE_O <= (st_d == ST_RUN); // [RQ1] [RQ9]
      FIRST_SHIFT_O  <= fir_sel_q; // [RQ7]
      MID_W_O        <= mid_w;
      MID_H_O        <= mid_h;
      H_MODE_O       <= hmode_q; // [RQ8]
      V_MODE_O       <= vmode_q;
      H_COEF_O       <= h_coef_d; // [RQ10]
      V_COEF_O       <= v_coef_d; // [RQ11]
      H_INIT_NUM_O   <= h_num_d;
      V_INIT_NUM_O   <= v_num_d;
      NUM_IGNORED_O  <= is_2x2; // [RQ14]
      IMG0_START_O   <= start0;
      IMG1_START_O   <= start1;
      IMG0_STRIDE_O  <= stride0;
      IMG1_STRIDE_O  <= stride1;
    end
  end

  assign REG_RDATA_O = rdata_q;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_tv_interlace_block: assert property ((CE_I && tv_block) |=> !SCALE_ACTIVE_O) // [RQ1]
    else $error("scaler active while tv interlace");
  a_zero_input_dims: assert property ((CE_I && (in_w_q == 12'h000 || in_h_q == 12'h000)) |=> !SCALE_ACTIVE_O) // [RQ3]
    else $error("scaler active with zero input size");
  a_zero_output_dims: assert property ((CE_I && (out_w_q == 14'h0000 || out_h_q == 14'h0000)) |=> !SCALE_ACTIVE_O) // [RQ5]
    else $error("scaler active with zero output size");
  a_first_stage_div: assert property ((CE_I && RST_N_I) |=> MID_W_O == 13'(({1'b0, $past(in_w_q)} + 13'h0001) >> $past(fir_sel_q))) // [RQ7]
    else $error("first stage width wrong");
  a_up_mode_reject: assert property ((CE_I && h_up && hmode_q == INTERP_NEAREST) |=> !SCALE_ACTIVE_O) // [RQ8]
    else $error("nearest mode accepted on up-scaling");
  a_bypass_holds_off: assert property ((CE_I && bypass_q) |=> !SCALE_ACTIVE_O) // [RQ9]
    else $error("scaler active while bypassed");
  a_h_coef_clamp: assert property ((CE_I && h_up && h_flr_q <= h_ceil_q) |=> (H_COEF_O >= $past(h_flr_q) && H_COEF_O <= $past(h_ceil_q))) // [RQ10]
    else $error("horizontal coefficient outside limits");
  a_v_coef_clamp: assert property ((CE_I && v_up && v_flr_q <= v_ceil_q) |=> (V_COEF_O >= $past(v_flr_q) && V_COEF_O <= $past(v_ceil_q))) // [RQ11]
    else $error("vertical coefficient outside limits");
  a_num_masked_2x: assert property ((CE_I && is_2x2) |=> (NUM_IGNORED_O && H_INIT_NUM_O == 8'h00 && V_INIT_NUM_O == 8'h00)) // [RQ14]
    else $error("numerators not ignored at 2x2");
  a_img0_start_calc: assert property ((CE_I && img0_scroll_on_q) |=> // [RQ15]
    IMG0_START_O == $past(IMG0_BASE_ADDR_I) +
    32'(({6'h00, $past(img0_start_skew_q)} * {5'h00, bpp_of($past(IMG0_PIXEL_FORMAT_I))}) >> 3))
    else $error("image 0 start address wrong");
  a_img1_plain_base: assert property ((CE_I && !img1_scroll_on_q) |=> IMG1_START_O == $past(IMG1_BASE_ADDR_I)) // [RQ17]
    else $error("image 1 start moved while scroll off");
  a_reserved_read: assert property ((CE_I && REG_RD_I && REG_ADDR_I == OFS_MISC) |=> REG_RDATA_O[31:9] == 23'h000000 && !REG_RDATA_O[5]) // [RQ20]
    else $error("reserved bits read nonzero");

  c_scaler_runs: cover property (CE_I && !bypass_q ##1 SCALE_ACTIVE_O);
  c_tv_hold: cover property (st_q == ST_RUN ##1 st_q == ST_HOLD);
  c_double_up: cover property (NUM_IGNORED_O && SCALE_ACTIVE_O);
  c_scroll_both: cover property (img0_scroll_on_q && img1_scroll_on_q && img0_start_skew_q != 5'h00);

endmodule
`default_nettype wire

//--- verilog/dsv_pkg.sv
// constants, types and shared functions of the display scaler and virtual-screen block
`default_nettype none
package dsv_pkg;

  // ***************************************************
  // register offsets
  // ***************************************************
  localparam logic [12:0] OFS_IN_W   = 13'h1100;
  localparam logic [12:0] OFS_IN_H   = 13'h1104;
  localparam logic [12:0] OFS_OUT_W  = 13'h1108;
  localparam logic [12:0] OFS_OUT_H  = 13'h110c;
  localparam logic [12:0] OFS_MISC   = 13'h1110;
  localparam logic [12:0] OFS_H_CEIL = 13'h1114;
  localparam logic [12:0] OFS_H_FLR  = 13'h1118;
  localparam logic [12:0] OFS_V_CEIL = 13'h111c;
  localparam logic [12:0] OFS_V_FLR  = 13'h1120;
  localparam logic [12:0] OFS_NUM    = 13'h112c;
  localparam logic [12:0] OFS_STAT   = 13'h1130;
  localparam logic [12:0] OFS_SCR0   = 13'h1500;
  localparam logic [12:0] OFS_SCR1   = 13'h1504;

  // ***************************************************
  // field positions, widths, limits, reset values
  // ***************************************************
  localparam int IN_DIM_W    = 12;
  localparam int OUT_DIM_W   = 14;
  localparam int TH_W        = 9;
  localparam int NUM_W       = 8;
  localparam int SKEW_W      = 5;
  localparam int STRIDE_W    = 12;
  localparam int STRIDE_B_W  = 15;
  localparam int MISC_FIR_LSB  = 6;
  localparam int MISC_HMOD_LSB = 3;
  localparam int MISC_VMOD_LSB = 1;
  localparam int MISC_BYP_BIT  = 0;
  localparam int NUM_H_LSB     = 8;
  localparam int SCR_EN_BIT    = 20;
  localparam int SCR_SKEW_LSB  = 12;
  localparam logic [11:0] IN_MAX  = 12'h7ff;
  localparam logic [13:0] OUT_MAX = 14'h1000;
  localparam logic        BYPASS_RST = 1'b1;

  typedef enum logic [1:0] {
    INTERP_BILIN   = 2'h0,
    INTERP_THRESH  = 2'h1,
    INTERP_NEAREST = 2'h2,
    INTERP_RSVD    = 2'h3
  } dsv_interp_e;

  typedef enum logic [2:0] {
    ST_OFF  = 3'h1,
    ST_RUN  = 3'h2,
    ST_HOLD = 3'h4
  } dsv_state_e;

  // bits per pixel of a pixel-format code
  function automatic logic [5:0] bpp_of(input logic [2:0] fmt);
    logic [5:0] b;
    b = 6'h01;
    case (fmt)
      3'h0: b = 6'h01;
      3'h1: b = 6'h02;
      3'h2: b = 6'h04;
      3'h3: b = 6'h08;
      3'h4: b = 6'h10;
      3'h5: b = 6'h18;
      3'h6: b = 6'h20;
      default: b = 6'h10;
    endcase
    return b;
  endfunction

  // pixel count left after the power-of-two first stage
  function automatic logic [12:0] first_stage(input logic [11:0] n_m1, input logic [2:0] sel);
    logic [12:0] cnt;
    cnt = {1'b0, n_m1} + 13'h0001;
    return cnt >> sel;
  endfunction

  // ceiling checked first, so with a floor above the ceiling a value above the ceiling yields the ceiling, any other the floor
  function automatic logic [8:0] clamp9(input logic [8:0] c, input logic [8:0] lo, input logic [8:0] hi);
    logic [8:0] r;
    r = c;
    if (c > hi)
      r = hi;
    else if (c < lo)
      r = lo;
    return r;
  endfunction

endpackage
`default_nettype wire

//--- verilog/dsv_scroll_addr.sv
// start address and line stride of one scrolled image
`default_nettype none
`timescale 1ns/10ps
module dsv_scroll_addr
  import dsv_pkg::*;
(
  input  wire logic [31:0]         base_i,
  input  wire logic                on_i,
  input  wire logic [SKEW_W-1:0]   skew_i,
  input  wire logic [STRIDE_W-1:0] stride_i,
  input  wire logic [2:0]          fmt_i,
  output logic      [31:0]         start_o,
  output logic      [STRIDE_B_W-1:0] stride_b_o
);

  wire logic [5:0]  bpp;
  wire logic [10:0] skew_bits;
  wire logic [17:0] line_bits;

  assign bpp = bpp_of(fmt_i); // [RQ19]
  // sub-byte remainders drop: skews must land on byte boundaries at low depths
  assign skew_bits  = {6'h00, skew_i} * {5'h00, bpp};
  assign line_bits  = {6'h00, stride_i} * {12'h000, bpp};
  assign start_o    = on_i ? base_i + {24'h000000, skew_bits[10:3]} : base_i; // [RQ15] [RQ17]
  assign stride_b_o = line_bits[17:3]; // [RQ16]

endmodule
`default_nettype wire

//--- sim/dsv_fb_model.sv
// frame-buffer side model: image base addresses and pixel formats
`timescale 1ns/10ps
`default_nettype none
module dsv_fb_model
(
  input  wire logic        clk_i,
  output logic      [31:0] base0_o,
  output logic      [31:0] base1_o,
  output logic      [2:0]  fmt0_o,
  output logic      [2:0]  fmt1_o
);
  initial
  begin
    base0_o = 32'h0;
    base1_o = 32'h0;
    fmt0_o  = 3'h0;
    fmt1_o  = 3'h0;
  end

  // a scroll step moves the base together with the offset register
  task automatic set_img(input logic [31:0] b0, input logic [31:0] b1, input logic [2:0] f0, input logic [2:0] f1);
    @(posedge clk_i);
    // line starts stay on four-word boundaries
    base0_o <= {b0[31:4], 4'h0};
    base1_o <= {b1[31:4], 4'h0};
    fmt0_o  <= f0;
    fmt1_o  <= f1;
  endtask
endmodule
`default_nettype wire

//--- sim/display_scaler_virtual_screen_test.sv
// self-checking bench of the scaler control and virtual-screen block
`timescale 1ns/10ps
`default_nettype none
module display_scaler_virtual_screen_test
  import dsv_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, tv = 1'b0, ii = 1'b0, oi = 1'b0;
  logic [12:0] addr = 13'h0;
  logic [31:0] wd = 32'h0, seed = 32'he5db7541;
  logic [8:0]  hc = 9'h0, vc = 9'h0;
  wire  [31:0] rdata, st0, st1, b0, b1;
  wire  [14:0] sd0, sd1;
  wire  [12:0] mw_o, mh_o;
  wire  [8:0]  hco, vco;
  wire  [7:0]  hn, vn;
  wire  [2:0]  f0, f1, fsh;
  wire  [1:0]  hm_o, vm_o;
  wire         act, ign;
  int          err_count = 0, num_checks = 0;
  int          bpt [8] = '{1, 2, 4, 8, 16, 24, 32, 16};
  logic [31:0] m [int];
  logic [31:0] bw [4] = '{32'd0, 32'd2047, 32'd2048, 32'd1};
  logic [31:0] bo [4] = '{32'd0, 32'd4096, 32'd4097, 32'd1};
  logic [31:0] mk [12] = '{32'hfff, 32'hfff, 32'h3fff, 32'h3fff, 32'h1df, 32'h1ff, 32'h1ff, 32'h1ff, 32'h1ff,
                           32'hffff, 32'h11ffff, 32'h11ffff};
  logic [12:0] ofs [12] = '{OFS_IN_W, OFS_IN_H, OFS_OUT_W, OFS_OUT_H, OFS_MISC, OFS_H_CEIL, OFS_H_FLR,
                            OFS_V_CEIL, OFS_V_FLR, OFS_NUM, OFS_SCR0, OFS_SCR1};

  dsv_top u_dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .TV_EN_I(tv), .IN_INTERLACE_I(ii), .OUT_INTERLACE_I(oi),
    .H_COEF_I(hc), .V_COEF_I(vc), .IMG0_BASE_ADDR_I(b0), .IMG1_BASE_ADDR_I(b1), .IMG0_PIXEL_FORMAT_I(f0),
    .IMG1_PIXEL_FORMAT_I(f1), .SCALE_ACTIVE_O(act), .FIRST_SHIFT_O(fsh), .MID_W_O(mw_o), .MID_H_O(mh_o),
    .H_MODE_O(hm_o), .V_MODE_O(vm_o), .H_COEF_O(hco), .V_COEF_O(vco), .H_INIT_NUM_O(hn), .V_INIT_NUM_O(vn),
    .NUM_IGNORED_O(ign), .IMG0_START_O(st0), .IMG1_START_O(st1), .IMG0_STRIDE_O(sd0), .IMG1_STRIDE_O(sd1)
  );
  dsv_fb_model u_fb (.clk_i(clk), .base0_o(b0), .base1_o(b1), .fmt0_o(f0), .fmt1_o(f1));

  initial
    forever #4 clk = ~clk;

  // ***************************************************
  // bus tasks, reference model and comparison
  // ***************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // with the floor set above the ceiling, the ceiling wins for values above it and the floor for the rest
  function automatic logic [8:0] clp(input logic [8:0] c, input logic [31:0] lo, input logic [31:0] hi);
    return (c > hi) ? hi[8:0] : (c < lo) ? lo[8:0] : c;
  endfunction

  // numerator software loads for 100 pixels or lines into the second stage
  function automatic logic [7:0] nm(input int o);
    return 8'((o > 100) ? 25600 / o : ((100 % o) * 256) / o);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wrr(input logic [12:0] a, input logic [31:0] d);
    @(posedge clk);
    wr   <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    wr <= 1'b0;
    foreach (ofs[i])
      if (ce && ofs[i] == a)
        m[a] = d & mk[i];
  endtask

  task automatic rdc(input logic [12:0] a);
    logic [31:0] e;
    e = m.exists(a) ? m[a] : 32'h0;
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e, "read back");
  endtask

  task automatic chk_img(input logic [31:0] s, input logic [31:0] b, input logic [2:0] f,
                         input logic [31:0] st, input logic [14:0] sd);
    int p;
    p = bpt[f];
    chk(st, s[20] ? b + 32'((int'(s[16:12]) * p) >> 3) : b, "start address");
    chk(sd, 32'((int'(s[11:0]) * p) >> 3), "line stride");
  endtask

  task automatic stl();
    int iw, ih, ow, oh, mw, mh;
    logic [31:0] c, n;
    logic uh, uv, two, ok;
    repeat (3) @(posedge clk);
    #1;
    c = m[OFS_MISC];
    n = m[OFS_NUM];
    iw = m[OFS_IN_W];
    ih = m[OFS_IN_H];
    ow = m[OFS_OUT_W];
    oh = m[OFS_OUT_H];
    mw = (iw + 1) >> c[8:6];
    mh = (ih + 1) >> c[8:6];
    uh = ow > mw;
    uv = oh > mh;
    two = (ow == 2 * mw) && (oh == 2 * mh);
    ok = !c[0] && iw inside {[1:2047]} && ih inside {[1:2047]} && ow inside {[1:4096]} && oh inside {[1:4096]}
         && c[4:3] != 2'h3 && c[2:1] != 2'h3 && !(uh && c[4:3] != 2'h0) && !(uv && c[2:1] != 2'h0);
    chk(act, ok && !(tv && (ii || oi)), "scaler active");
    chk(fsh, c[8:6], "first stage shift");
    chk(mw_o, mw, "mid width");
    chk(mh_o, mh, "mid height");
    chk({hm_o, vm_o}, c[4:1], "modes");
    chk(hco, uh ? clp(hc, m[OFS_H_FLR], m[OFS_H_CEIL]) : hc, "h coefficient");
    chk(vco, uv ? clp(vc, m[OFS_V_FLR], m[OFS_V_CEIL]) : vc, "v coefficient");
    chk({ign, hn, vn}, two ? 32'h10000 : {16'h0, n[15:0]}, "numerators");
    chk_img(m[OFS_SCR0], b0, f0, st0, sd0);
    chk_img(m[OFS_SCR1], b1, f1, st1, sd1);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ***************************************************
  // main sequence and watchdog
  // ***************************************************
  initial
  begin
    foreach (ofs[i])
      m[ofs[i]] = (ofs[i] == OFS_MISC) ? 32'h1 : 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[i])
      rdc(ofs[i]);
    foreach (ofs[i])
    begin
      wrr(ofs[i], 32'hffffffff);
      rdc(ofs[i]);
    end
    wrr(13'h1124, 32'hffffffff);
    rdc(13'h1124);
    // a strobe under a low clock enable is lost
    ce <= 1'b0;
    wrr(OFS_IN_W, 32'h5);
    ce <= 1'b1;
    rdc(OFS_IN_W);
    $display("register test done");
    wrr(OFS_IN_W, 32'd99);
    wrr(OFS_IN_H, 32'd99);
    wrr(OFS_OUT_W, 32'd50);
    wrr(OFS_OUT_H, 32'd50);
    for (int k = 0; k < 128; k++)
    begin
      wrr(OFS_MISC, 32'({k[6:4], 1'b0, k[3:2], k[1:0], 1'b0}));
      stl();
    end
    wrr(OFS_MISC, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      {tv, ii, oi} <= k[2:0]; // interlaced tv belongs to the simple scaler, this one stays off
      stl();
    end
    {tv, ii, oi} <= 3'h0;
    foreach (bw[i])
    begin
      wrr(OFS_IN_W, bw[i]);
      wrr(OFS_OUT_H, bo[i]);
      stl();
    end
    $display("scaler mode test done");
    wrr(OFS_IN_W, 32'd99);
    for (int k = 0; k < 12; k++)
    begin
      wrr(OFS_OUT_W, 32'(199 + k % 3));
      wrr(OFS_OUT_H, (k < 6) ? 32'd200 : 32'd60);
      wrr(OFS_H_CEIL, rnd());
      wrr(OFS_H_FLR, rnd());
      wrr(OFS_V_CEIL, rnd());
      wrr(OFS_V_FLR, rnd());
      wrr(OFS_NUM, {16'h0, nm(199 + k % 3), nm((k < 6) ? 200 : 60)});
      @(posedge clk);
      hc <= 9'(rnd());
      vc <= 9'(rnd());
      stl();
    end
    $display("upscale test done");
    for (int k = 0; k < 16; k++)
    begin
      u_fb.set_img(rnd(), rnd(), 3'(k), 3'(k + 3));
      wrr(OFS_SCR0, rnd());
      wrr(OFS_SCR1, rnd());
      stl();
    end
    $display("scroll test done");
    finish_test();
  end

  initial
  begin
    #200000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
